// *** shared/acis_pkg.sv ***
`default_nettype none
// Shared constants for the converter clock and input select block
package acis_pkg;

  // Register byte addresses
  localparam logic [7:0] ACIS_OFS_CLK_SAMPLE = 8'h00; // adc_clock_sample_control
  localparam logic [7:0] ACIS_OFS_INPUT_SEL = 8'h04;  // adc_input_select
  localparam logic [7:0] ACIS_OFS_SCAN_LOW = 8'h08;   // adc_scan_select_low
  localparam logic [7:0] ACIS_OFS_SEQ_CTRL = 8'h0c;   // Sequencer control
  localparam logic [7:0] ACIS_OFS_SEQ_STAT = 8'h10;   // Sequencer status

  // Clock and sample control fields
  localparam int ACIS_CLK_SRC_BIT = 15;
  localparam int ACIS_AUTO_SAMPLE_TIME_LSB = 8;
  localparam int ACIS_AUTO_SAMPLE_TIME_W = 5;
  localparam int ACIS_DIV_LSB = 0;
  localparam int ACIS_DIV_W = 8;

  // Input select fields
  localparam int ACIS_NEG_B_BIT = 31;
  localparam int ACIS_POS_B_LSB = 24;
  localparam int ACIS_NEG_A_BIT = 23;
  localparam int ACIS_POS_A_LSB = 16;
  localparam int ACIS_POS_W = 6;

  // Sequencer control fields
  localparam int ACIS_TRIG_LSB = 0;
  localparam int ACIS_TRIG_W = 3;
  localparam int ACIS_ALT_BIT = 3;
  localparam int ACIS_SCAN_BIT = 4;
  localparam int ACIS_START_BIT = 8;

  // Writable masks; everything else reads zero
  localparam logic [31:0] ACIS_CLK_SAMPLE_MASK = 32'h0000_9fff;
  localparam logic [31:0] ACIS_INPUT_SEL_MASK = 32'hbfbf_0000;
  localparam logic [31:0] ACIS_SEQ_CTRL_MASK = 32'h0000_001f;

  // Reset values
  localparam logic [31:0] ACIS_REG_RESET = 32'h0000_0000;

  // Trigger source code for the internal auto-convert counter
  localparam logic [2:0] ACIS_TRIG_AUTO = 3'h7;

  // Positive input codes, smaller package
  localparam logic [5:0] ACIS_S_LAST_AIN = 6'h1b;
  localparam logic [5:0] ACIS_S_BANDGAP = 6'h1c;
  localparam logic [5:0] ACIS_S_TEMP = 6'h1d;
  localparam logic [5:0] ACIS_S_OPEN = 6'h1e;
  // Positive input codes, larger package
  localparam logic [5:0] ACIS_L_LAST_AIN = 6'h2f;
  localparam logic [5:0] ACIS_L_BANDGAP = 6'h30;
  localparam logic [5:0] ACIS_L_TEMP = 6'h31;
  localparam logic [5:0] ACIS_L_OPEN = 6'h32;

  // Sequencer states, gray coded along idle, sample, convert
  typedef enum logic [1:0] {
    ACIS_IDLE = 2'b00,
    ACIS_SAMPLE = 2'b01,
    ACIS_CONVERT = 2'b11
  } acis_state_e;

endpackage
`default_nettype wire

// *** rtl/acis_top.sv ***
// Notes on behaviour
// [RULE1] Bit 15 picks fast RC or bus clock
// [RULE2] Bus divider period is 2*(div+1) cycles
// [RULE3] Auto-sample field used only in auto-convert
// [RULE4] Divider ignored when RC source selected
// [RULE5] Bit 31 picks sample B negative input
// [RULE6] Bit 23 picks sample A negative input
// [RULE7] Bits 29:24 hold sample B positive select
// [RULE8] Bits 21:16 hold sample A positive select
// [RULE9] Small package codes: inputs, band-gap, sensor, open
// [RULE10] Large package codes: inputs, band-gap, sensor, open
// [RULE11] Open input only for charge timing use
// [RULE12] Band-gap code routes 1.2V reference input
// [RULE13] Unimplemented bits read zero, ignore writes
// [RULE14] Auto mode samples for programmed clock periods
// [RULE15] Trigger code 111 ends sampling by counter
// [RULE16] Alternate mode: A first, then B, A
// [RULE17] Scan mask bit x includes input x
`default_nettype none
module acis_top
  import acis_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1 // Larger package code map
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frc_tick,
  input wire logic trig_end,
  input wire logic conv_done,
  output logic conv_tick,
  output logic sampling,
  output logic conv_start,
  output logic [5:0] pos_sel,
  output logic neg_ain1,
  output logic pos_is_ain,
  output logic pos_bandgap,
  output logic pos_temp,
  output logic pos_open,
  output logic use_b
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  // All state of the block in one record
  typedef struct packed {
    logic [31:0] clk_ctl;   // Clock and sample control
    logic [31:0] in_sel;    // Input select
    logic [31:0] scan;      // Scan mask
    logic [31:0] seq_ctl;   // Sequencer control
    logic [8:0] div_cnt;    // Bus clock divider count
    logic tick;             // Conversion clock period pulse
    acis_state_e st;        // Sequencer state
    logic [4:0] samp_cnt;   // Auto-sample period count
    logic b_next;           // Next sample uses B
    logic b_now;            // Current sample uses B
    logic [4:0] scan_ptr;   // Current scan input
    logic start_conv;       // Convert pulse
    logic samp;             // Sequencer is sampling
    logic [5:0] pos;        // Driven positive code
    logic neg;              // Driven negative select
    logic [3:0] pos_kind;   // Ain, band-gap, temp, open
    logic [31:0] rdata;     // Read data
    logic ready;            // Access answer
    logic err;              // Unmapped access
  } acis_state_s;

  acis_state_s cur_q;
  acis_state_s nxt_d;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Classify a positive code for the chosen package
  function automatic logic [3:0] pos_class(input logic [5:0] code);
    logic [3:0] kind;
    kind = 4'h0;
    if (LARGE_PKG) begin
      // [RULE10] Large package map
      if (code <= ACIS_L_LAST_AIN) begin
        kind = 4'h1;
      end else if (code == ACIS_L_BANDGAP) begin
        kind = 4'h2;
      end else if (code == ACIS_L_TEMP) begin
        kind = 4'h4;
      end else if (code == ACIS_L_OPEN) begin
        kind = 4'h8;
      end
    end else begin
      // [RULE9] Small package map
      if (code <= ACIS_S_LAST_AIN) begin
        kind = 4'h1;
      end else if (code == ACIS_S_BANDGAP) begin
        kind = 4'h2;
      end else if (code == ACIS_S_TEMP) begin
        kind = 4'h4;
      end else if (code == ACIS_S_OPEN) begin
        kind = 4'h8;
      end
    end
    return kind;
  endfunction

  // Next set bit of the mask after the pointer, wrapping
  function automatic logic [4:0] scan_next(input logic [31:0] mask, input logic [4:0] ptr);
    logic [4:0] res;
    logic found;
    logic [4:0] idx;
    res = ptr;
    found = 1'b0;
    for (int i = 1; i <= 32; i++) begin
      idx = 5'(int'(ptr) + i);
      if (!found && mask[idx]) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // Masked register write
  function automatic logic [31:0] wr_mask(input logic [31:0] old, input logic [31:0] val,
                                          input logic [31:0] mask);
    return (old & ~mask) | (val & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field views

  logic clk_from_rc;
  logic [7:0] div_val;
  logic [4:0] auto_sample_time;
  logic [2:0] trig_sel;
  logic wr_acc;
  logic rd_acc;

  assign clk_from_rc = cur_q.clk_ctl[ACIS_CLK_SRC_BIT];
  assign div_val = cur_q.clk_ctl[ACIS_DIV_LSB +: ACIS_DIV_W];
  assign auto_sample_time = cur_q.clk_ctl[ACIS_AUTO_SAMPLE_TIME_LSB +: ACIS_AUTO_SAMPLE_TIME_W];
  assign trig_sel = cur_q.seq_ctl[ACIS_TRIG_LSB +: ACIS_TRIG_W];
  // Access phase, answered one cycle after it opens
  assign wr_acc = psel && penable && !cur_q.ready && pwrite;
  assign rd_acc = psel && penable && !cur_q.ready && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Bus slave, clock divider and sample sequencer
  always_comb begin
    logic start_req;
    logic end_samp;
    logic [8:0] div_end;
    logic [5:0] code;
    logic alt_now; // Alternate mode after this cycle's write
    logic scan_now; // Scan mode after this cycle's write
    start_req = 1'b0;
    alt_now = 1'b0;
    scan_now = 1'b0;
    end_samp = 1'b0;
    div_end = 9'h000;
    code = 6'h00;
    nxt_d = cur_q;
    nxt_d.start_conv = 1'b0;
    nxt_d.tick = 1'b0;
    nxt_d.ready = 1'b0;
    nxt_d.err = 1'b0;

    // Register writes; reserved bits keep zero
    if (wr_acc) begin
      nxt_d.ready = 1'b1;
      case (paddr)
        ACIS_OFS_CLK_SAMPLE: begin
          // [RULE13] Masked control write
          nxt_d.clk_ctl = wr_mask(cur_q.clk_ctl, pwdata, ACIS_CLK_SAMPLE_MASK);
        end
        ACIS_OFS_INPUT_SEL: begin
          // [RULE13] Masked select write
          nxt_d.in_sel = wr_mask(cur_q.in_sel, pwdata, ACIS_INPUT_SEL_MASK);
        end
        ACIS_OFS_SCAN_LOW: begin
          // [RULE17] Full scan mask
          nxt_d.scan = pwdata;
        end
        ACIS_OFS_SEQ_CTRL: begin
          nxt_d.seq_ctl = wr_mask(cur_q.seq_ctl, pwdata, ACIS_SEQ_CTRL_MASK);
          start_req = pwdata[ACIS_START_BIT];
        end
        ACIS_OFS_SEQ_STAT: begin
          // Status is read only
        end
        default: begin
          nxt_d.err = 1'b1;
        end
      endcase
    end

    // Register reads
    if (rd_acc) begin
      nxt_d.ready = 1'b1;
      case (paddr)
        ACIS_OFS_CLK_SAMPLE: nxt_d.rdata = cur_q.clk_ctl;
        ACIS_OFS_INPUT_SEL: nxt_d.rdata = cur_q.in_sel;
        ACIS_OFS_SCAN_LOW: nxt_d.rdata = cur_q.scan;
        ACIS_OFS_SEQ_CTRL: nxt_d.rdata = cur_q.seq_ctl;
        ACIS_OFS_SEQ_STAT: begin
          nxt_d.rdata = {19'h00000, cur_q.scan_ptr, 2'h0, cur_q.b_next,
                         cur_q.b_now, 2'h0, cur_q.st};
        end
        default: begin
          nxt_d.rdata = 32'h0000_0000;
          nxt_d.err = 1'b1;
        end
      endcase
    end

    // Mode bits as they stand after this cycle's write, so a start
    // written together with a new mode already follows that mode
    alt_now = nxt_d.seq_ctl[ACIS_ALT_BIT];
    scan_now = nxt_d.seq_ctl[ACIS_SCAN_BIT];

    // Conversion clock period pulse
    if (clk_from_rc) begin
      // [RULE1] Fast RC supplies the period
      // [RULE4] Divider unused, count cleared
      nxt_d.tick = frc_tick;
      nxt_d.div_cnt = 9'h000;
    end else begin
      // [RULE2] Period is 2*(div+1) bus cycles
      div_end = {div_val, 1'b1};
      if (cur_q.div_cnt >= div_end) begin
        nxt_d.div_cnt = 9'h000;
        nxt_d.tick = 1'b1;
      end else begin
        nxt_d.div_cnt = 9'(cur_q.div_cnt + 9'h001);
      end
    end

    // Sample sequencer
    case (cur_q.st)
      ACIS_IDLE: begin
        if (start_req) begin
          nxt_d.st = ACIS_SAMPLE;
          nxt_d.samp_cnt = 5'h00;
          // [RULE16] Pick A or B for this sample
          nxt_d.b_now = alt_now && cur_q.b_next;
          nxt_d.b_next = alt_now && !cur_q.b_next;
          if (scan_now) begin
            // [RULE17] Step to next selected input
            nxt_d.scan_ptr = scan_next(cur_q.scan, cur_q.scan_ptr);
          end
        end
      end
      ACIS_SAMPLE: begin
        if (trig_sel == ACIS_TRIG_AUTO) begin
          // [RULE15] Counter ends sampling
          // [RULE14] Hold for programmed conversion clock periods
          if (cur_q.tick) begin
            if (cur_q.samp_cnt >= auto_sample_time) begin
              end_samp = 1'b1;
            end else begin
              nxt_d.samp_cnt = 5'(cur_q.samp_cnt + 5'h01);
            end
          end
        end else begin
          // [RULE3] Sample time ignored, outside trigger ends it
          end_samp = trig_end;
        end
        if (end_samp) begin
          nxt_d.st = ACIS_CONVERT;
          nxt_d.start_conv = 1'b1;
        end
      end
      ACIS_CONVERT: begin
        if (conv_done) begin
          nxt_d.st = ACIS_IDLE;
        end
      end
      default: begin
        nxt_d.st = ACIS_IDLE;
      end
    endcase

    // Sampling level kept in a flop so the pin needs no decode
    nxt_d.samp = (nxt_d.st == ACIS_SAMPLE);

    // Alternate mode off restarts on sample A
    if (!alt_now) begin
      nxt_d.b_next = 1'b0;
    end

    // Multiplexer drive from the settings in use
    if (nxt_d.b_now) begin
      // [RULE7] Sample B positive field
      code = nxt_d.in_sel[ACIS_POS_B_LSB +: ACIS_POS_W];
      // [RULE5] Sample B negative: input 1 or low reference
      nxt_d.neg = nxt_d.in_sel[ACIS_NEG_B_BIT];
    end else begin
      // [RULE8] Sample A positive field
      code = nxt_d.in_sel[ACIS_POS_A_LSB +: ACIS_POS_W];
      // [RULE6] Sample A negative: input 1 or low reference
      nxt_d.neg = nxt_d.in_sel[ACIS_NEG_A_BIT];
    end
    if (scan_now) begin
      code = {1'b0, nxt_d.scan_ptr};
    end
    nxt_d.pos = code;
    // [RULE12] Band-gap code raises the reference route
    nxt_d.pos_kind = pos_class(code);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Synchronous reset to zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  assign prdata = cur_q.rdata;
  assign pready = cur_q.ready;
  assign pslverr = cur_q.err;
  assign conv_tick = cur_q.tick;
  assign sampling = cur_q.samp;
  assign conv_start = cur_q.start_conv;
  assign pos_sel = cur_q.pos;
  assign neg_ain1 = cur_q.neg;
  assign pos_is_ain = cur_q.pos_kind[0];
  assign pos_bandgap = cur_q.pos_kind[1];
  assign pos_temp = cur_q.pos_kind[2];
  assign pos_open = cur_q.pos_kind[3];
  assign use_b = cur_q.b_now;

endmodule
`default_nettype wire

// *** verif/acis_props.sv ***
`default_nettype none
module acis_props
  import acis_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1 // Larger package code map
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frc_tick,
  input wire logic trig_end,
  input wire logic conv_tick,
  input wire logic sampling,
  input wire logic conv_start,
  input wire logic [5:0] pos_sel,
  input wire logic pos_bandgap,
  input wire logic pos_temp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  logic src_q; // Shadow of the clock source bit
  logic fresh_q; // Set by a config write, cleared by the next conversion tick
  logic [7:0] div_q; // Shadow of the divider
  logic [2:0] trg_q; // Shadow of the trigger source
  logic [9:0] gap_q; // Cycles since the last conversion tick
  logic wr; // Write taken this cycle
  assign wr = psel && penable && pwrite && !pready;
  // Track the writes that shape the conversion clock and trigger
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      src_q <= 1'b0;
      div_q <= 8'h00;
      trg_q <= 3'h0;
      fresh_q <= 1'b1;
      gap_q <= 10'h000;
    end else begin
      gap_q <= conv_tick ? 10'h001 : gap_q + 10'h001;
      fresh_q <= (wr && paddr == ACIS_OFS_CLK_SAMPLE) ? 1'b1 : (conv_tick ? 1'b0 : fresh_q);
      if (wr && paddr == ACIS_OFS_CLK_SAMPLE) begin
        src_q <= pwdata[ACIS_CLK_SRC_BIT];
        div_q <= pwdata[7:0];
      end
      if (wr && paddr == ACIS_OFS_SEQ_CTRL) begin
        trg_q <= pwdata[2:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence apb_acc;
    psel && penable && !pready;
  endsequence
  sequence rd_done(logic [7:0] a);
    pready && !pwrite && paddr == a;
  endsequence
  apb_answer_a: assert property (apb_acc |=> pready)
    else $error("access not answered next cycle");
  err_pulse_a: assert property (pslverr |-> pready ##1 !pslverr)
    else $error("error flag without answer");
  clk_rsvd_a: assert property (rd_done(ACIS_OFS_CLK_SAMPLE) |->
    (prdata & 32'hffff_6000) == 32'h0)
    else $error("clock control reserved bits set");
  sel_rsvd_a: assert property (rd_done(ACIS_OFS_INPUT_SEL) |->
    (prdata & 32'h4040_ffff) == 32'h0)
    else $error("input select reserved bits set");
  rc_follow_a: assert property (src_q && $past(src_q) |-> conv_tick == $past(frc_tick))
    else $error("tick does not follow fast rc");
  div_period_a: assert property (conv_tick && !fresh_q && !src_q |->
    gap_q == {1'b0, div_q, 1'b0} + 10'h002)
    else $error("bus clock tick period wrong");
  trig_end_a: assert property (sampling && trig_end && trg_q != ACIS_TRIG_AUTO |=>
    conv_start)
    else $error("trigger did not end sampling");
  start_pulse_a: assert property (conv_start |->
    $past(sampling) && !sampling ##1 !conv_start)
    else $error("start pulse malformed");
  bandgap_code_a: assert property (pos_bandgap |->
    pos_sel == (LARGE_PKG ? ACIS_L_BANDGAP : ACIS_S_BANDGAP))
    else $error("band-gap flag on wrong code");
  temp_code_a: assert property (pos_temp |->
    pos_sel == (LARGE_PKG ? ACIS_L_TEMP : ACIS_S_TEMP))
    else $error("sensor flag on wrong code");
endmodule
bind acis_top acis_props #(.LARGE_PKG(LARGE_PKG)) props_i (.mclk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .frc_tick, .trig_end, .conv_tick, .sampling,
  .conv_start, .pos_sel, .pos_bandgap, .pos_temp);
`default_nettype wire

// *** verif/acis_conv_model.sv ***
`default_nettype none
module acis_conv_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic conv_start,
  output logic conv_done = 1'b0,
  output logic frc_tick = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] busy_q = 4'h0; // Cycles left in the conversion
  logic [1:0] rc_q = 2'h0; // Fast RC oscillator divider
  // Converter answers promptly or slowly; RC tick every third cycle
  always @(posedge mclk) begin
    if (!rst_n) begin
      busy_q <= 4'h0;
      rc_q <= 2'h0;
      conv_done <= 1'b0;
      frc_tick <= 1'b0;
    end else begin
      rc_q <= (rc_q == 2'h2) ? 2'h0 : rc_q + 2'h1;
      frc_tick <= (rc_q == 2'h2);
      conv_done <= (busy_q == 4'h1);
      if (conv_start) begin
        busy_q <= slow ? 4'hc : 4'h2;
      end else if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/acis_top_tb.sv ***
`default_nettype none
module acis_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acis_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic trig_end = 1'b0, slow = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, tick_cnt = 32'h0, t0;
  logic pready, pslverr, frc_tick, conv_done, conv_tick, sampling, conv_start;
  logic neg_ain1, pos_is_ain, pos_bandgap, pos_temp, pos_open, use_b;
  logic [5:0] pos_sel;
  logic [7:0] ofs [3] = '{ACIS_OFS_CLK_SAMPLE, ACIS_OFS_INPUT_SEL, ACIS_OFS_SCAN_LOW};
  logic [31:0] wm [3] = '{32'h0000_9fff, 32'hbfbf_0000, 32'hffff_ffff};
  logic [5:0] codes [4] = '{6'h2f, 6'h30, 6'h31, 6'h32};
  int error_cnt = 0, num_checks = 0;
  acis_top uut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .frc_tick, .trig_end, .conv_done, .conv_tick, .sampling, .conv_start, .pos_sel,
    .neg_ain1, .pos_is_ain, .pos_bandgap, .pos_temp, .pos_open, .use_b);
  acis_conv_model model (.mclk, .rst_n, .slow, .conv_start, .conv_done, .frc_tick);
  always #10 mclk = ~mclk;
  // Ticks seen while sampling
  always @(posedge mclk) begin
    if (sampling === 1'b1 && conv_tick === 1'b1) tick_cnt <= tick_cnt + 32'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One bus transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait for sampling (0), conversion start (1) or done (2)
  task automatic wait_on(input int k);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      trig_end <= 1'b0;
      n++;
    end while (!(k == 0 ? sampling === 1'b1 : k == 1 ? conv_start === 1'b1
      : conv_done === 1'b1) && n < 300);
    if (n >= 300) begin
      error_cnt++;
      close_out();
    end
  endtask
  // One start: check mux state, trigger, count ticks until conversion
  task automatic samp(input logic [31:0] ctl, input logic [5:0] ps, input logic b);
    t0 = tick_cnt;
    apb(ACIS_OFS_SEQ_CTRL, 1'b1, ctl | 32'h0000_0100);
    wait_on(0);
    chk({26'h0, pos_sel}, {26'h0, ps});
    chk({31'h0, use_b}, {31'h0, b});
    chk({31'h0, neg_ain1}, {31'h0, b});
    trig_end <= 1'b1;
    wait_on(1);
    t0 = tick_cnt - t0;
    wait_on(2);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(ofs[i], 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(ofs[i], 1'b1, 32'hffff_ffff);
      apb(ofs[i], 1'b0, 32'h0);
      chk(rd, wm[i]);
    end
    apb(8'h14, 1'b1, 32'hffff_ffff);
    apb(8'h14, 1'b0, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    // Long sample time must not matter outside auto mode
    apb(ACIS_OFS_CLK_SAMPLE, 1'b1, 32'h0000_1f01);
    apb(ACIS_OFS_INPUT_SEL, 1'b1, 32'hb005_0000);
    samp(32'h08, 6'h05, 1'b0);
    samp(32'h08, 6'h30, 1'b1);
    samp(32'h08, 6'h05, 1'b0);
    apb(ACIS_OFS_SEQ_CTRL, 1'b1, 32'h0);
    // Input codes near the top of the map, classified without converting
    for (int i = 0; i < 4; i++) begin
      apb(ACIS_OFS_INPUT_SEL, 1'b1, {10'h0, codes[i], 16'h0});
      repeat (2) @(posedge mclk);
      chk({28'h0, pos_is_ain, pos_bandgap, pos_temp, pos_open}, 32'h8 >> i);
    end
    // Ordinary conversions go back to a real input, never the open code
    apb(ACIS_OFS_INPUT_SEL, 1'b1, 32'h0005_0000);
    apb(ACIS_OFS_CLK_SAMPLE, 1'b1, 32'h0000_0201);
    samp(32'h07, 6'h05, 1'b0);
    chk(t0, 32'h3);
    slow <= 1'b1;
    apb(ACIS_OFS_CLK_SAMPLE, 1'b1, 32'h0000_80ff);
    samp(32'h07, 6'h05, 1'b0);
    chk(t0, 32'h1);
    apb(ACIS_OFS_SCAN_LOW, 1'b1, 32'h0000_0014);
    samp(32'h10, 6'h02, 1'b0);
    samp(32'h10, 6'h04, 1'b0);
    samp(32'h10, 6'h02, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
